// File: hw/i2ctic_cfg.svh
// Offsets, field positions and reset values of the target interrupt-clear and alternate-address block
// ==========================================================================
// How it works
// - Writing one to clear bit 8 drops raw and masked receive-FIFO-full flags.
// - Writing one to clear bit 7 drops raw and masked transmit-FIFO-empty flags.
// - Writing one to clear bit 6 drops raw and masked receive-request flags.
// - Writing one to clear bit 5 drops raw and masked transmit-request flags.
// - Writing one to clear bit 4 drops raw and masked transmit-DMA-done flags.
// - Writing one to clear bit 3 drops raw and masked receive-DMA-done flags.
// - Writing one to clear bit 1 drops raw and masked START flags.
// - Clear register is write-only; reads return zero and change no flag.
// - Alternate enable, bit 7, resets 0; when set the target also answers there.
// - Bits 6-0 hold the writable seven-bit alternate address, reset zero.
// - A masked flag reads one only while its raw flag and mask are both set.
`ifndef I2CTIC_CFG_SVH
`define I2CTIC_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define I2CTIC_ADDR_W 12
`define I2CTIC_OFS_OWN_ADDR 12'h800
`define I2CTIC_OFS_MASK 12'h80C
`define I2CTIC_OFS_RAW 12'h810
`define I2CTIC_OFS_MASKED 12'h814
`define I2CTIC_OFS_CLEAR 12'h818
`define I2CTIC_OFS_ALT_ADDR 12'h81C

// ==========================================================================
// Interrupt flag positions, shared by raw, mask, masked and clear registers
`define I2CTIC_NUM_FLAGS 9
`define I2CTIC_BIT_TARGET_DATA 0
`define I2CTIC_BIT_START 1
`define I2CTIC_BIT_STOP 2
`define I2CTIC_BIT_RX_DMA_DONE 3
`define I2CTIC_BIT_TX_DMA_DONE 4
`define I2CTIC_BIT_TX_REQUEST 5
`define I2CTIC_BIT_RX_REQUEST 6
`define I2CTIC_BIT_TX_FIFO_EMPTY 7
`define I2CTIC_BIT_RX_FIFO_FULL 8

// ==========================================================================
// Address register fields
`define I2CTIC_BIT_ALT_EN 7
`define I2CTIC_ADDR_BITS 7

// ==========================================================================
// Reset values
`define I2CTIC_RST_FLAGS 9'h000
`define I2CTIC_RST_MASK 9'h000
`define I2CTIC_RST_ADDR 7'h00
`define I2CTIC_RST_ALT_EN 1'h0
`define I2CTIC_RST_RDATA 32'h00000000
`define I2CTIC_CLEAR_READ_VALUE 32'h00000000

// ==========================================================================
// Frame timing: address bits before the acknowledge slot
`define I2CTIC_ADDR_FRAME_BITS 4'h8

`endif

// File: hw/i2ctic_pkg.sv
// Types shared by the target interrupt-clear and alternate-address block
package i2ctic_pkg;

	// ==========================================================================
	// Register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} i2ctic_bus_req_type;

	// ==========================================================================
	// Events from the FIFO and DMA logic, one-cycle pulses on the core clock
	typedef struct packed {
		logic rx_fifo_full;
		logic tx_fifo_empty;
		logic rx_request;
		logic tx_request;
		logic tx_dma_done;
		logic rx_dma_done;
	} i2ctic_ext_evt_type;

	// ==========================================================================
	// Events seen on the serial bus, one-cycle pulses
	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic addr_match;
		logic alt_hit;
		logic rnw;
	} i2ctic_link_evt_type;

	// ==========================================================================
	// Address phase of the target
	typedef enum logic [1:0] {
		I2CTIC_IDLE,
		I2CTIC_ADDR,
		I2CTIC_ACK,
		I2CTIC_WAIT
	} i2ctic_phase_type;

endpackage

// File: hw/i2ctic_sync.sv
// Two-flop synchroniser for the serial bus pins
`timescale 1ns/1ps
module i2ctic_sync #(
	parameter int WIDTH = 2
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	import i2ctic_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} i2ctic_sync_state_type;

	i2ctic_sync_state_type state_reg;
	i2ctic_sync_state_type state_next;

	// ==========================================================================
	// Second stage only ever reads the first; idle bus level is high
	always_comb begin
		state_next.meta = i_async;
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_reg <= {(2*WIDTH){1'b1}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_sync = state_reg.stable;
endmodule

// File: hw/i2ctic_flag_bank.sv
// Sticky raw interrupt flags with write-one-to-clear and mask gating
`timescale 1ns/1ps
`include "i2ctic_cfg.svh"
module i2ctic_flag_bank #(
	parameter int WIDTH = `I2CTIC_NUM_FLAGS
) (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic [WIDTH-1:0] i_set,
	input wire logic [WIDTH-1:0] i_clear,
	input wire logic [WIDTH-1:0] i_mask,
	output logic [WIDTH-1:0] o_raw,
	output logic [WIDTH-1:0] o_masked
);
	import i2ctic_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] raw;
	} i2ctic_flag_state_type;

	i2ctic_flag_state_type state_reg;
	i2ctic_flag_state_type state_next;

	// ==========================================================================
	// Set is applied after clear so an event in the clearing cycle survives
	always_comb begin
		state_next.raw = (state_reg.raw & ~i_clear) | i_set;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_reg.raw <= WIDTH'(`I2CTIC_RST_FLAGS);
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Masked view has no storage of its own, so clearing raw clears it too
	assign o_raw = state_reg.raw;
	assign o_masked = state_reg.raw & i_mask;
endmodule

// File: hw/i2ctic_top.sv
// Target interrupt clear, alternate own address and address-phase responder
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "i2ctic_cfg.svh"
module i2ctic_top (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire i2ctic_pkg::i2ctic_bus_req_type i_bus,
	output logic [31:0] o_rdata,
	input wire i2ctic_pkg::i2ctic_ext_evt_type i_ext_evt,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	output i2ctic_pkg::i2ctic_link_evt_type o_link_evt,
	output logic [8:0] o_raw_status,
	output logic [8:0] o_masked_status
);
	import i2ctic_pkg::*;

	// ==========================================================================
	// State of the block; raw flags and pin synchroniser are held in u_flags and u_sync
	typedef struct packed {
		logic [6:0] own_addr;
		logic [6:0] alt_addr;
		logic alt_en;
		logic [8:0] mask;
		logic [31:0] rdata;
		logic scl_prev;
		logic sda_prev;
		i2ctic_phase_type phase;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic drive_low;
		i2ctic_link_evt_type evt;
	} i2ctic_top_state_type;

	i2ctic_top_state_type state_reg;
	i2ctic_top_state_type state_next;

	logic [1:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic [8:0] raw_flags;
	logic [8:0] masked_flags;
	logic [8:0] set_vec;
	logic [8:0] clear_vec;
	logic wr_hit_clear;

	// ==========================================================================
	// Decoding and compare helpers
	function automatic logic sel(input logic [11:0] addr, input logic [11:0] ofs);
		sel = (addr == ofs);
	endfunction

	function automatic logic addr_hit(input logic [6:0] rx, input logic [6:0] mine, input logic en);
		addr_hit = en && (rx == mine);
	endfunction

	// ==========================================================================
	// Pins cross into the core clock before anything looks at them
	i2ctic_sync #(
		.WIDTH(2)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_scl, i_sda}),
		.o_sync(pins_sync)
	);

	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// ==========================================================================
	// Event sources and write-one-to-clear vector; a read never reaches clear_vec
	assign wr_hit_clear = i_bus.wr && sel(i_bus.addr, `I2CTIC_OFS_CLEAR);
	assign clear_vec = wr_hit_clear ? i_bus.wdata[8:0] : 9'h000;

	always_comb begin
		set_vec = 9'h000;
		set_vec[`I2CTIC_BIT_TARGET_DATA] = state_reg.evt.addr_match;
		set_vec[`I2CTIC_BIT_START] = state_reg.evt.start_seen;
		set_vec[`I2CTIC_BIT_STOP] = state_reg.evt.stop_seen;
		set_vec[`I2CTIC_BIT_RX_DMA_DONE] = i_ext_evt.rx_dma_done;
		set_vec[`I2CTIC_BIT_TX_DMA_DONE] = i_ext_evt.tx_dma_done;
		set_vec[`I2CTIC_BIT_TX_REQUEST] = i_ext_evt.tx_request;
		set_vec[`I2CTIC_BIT_RX_REQUEST] = i_ext_evt.rx_request;
		set_vec[`I2CTIC_BIT_TX_FIFO_EMPTY] = i_ext_evt.tx_fifo_empty;
		set_vec[`I2CTIC_BIT_RX_FIFO_FULL] = i_ext_evt.rx_fifo_full;
	end

	// ==========================================================================
	// Raw and masked flag storage
	i2ctic_flag_bank #(
		.WIDTH(`I2CTIC_NUM_FLAGS)
	) u_flags (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_set(set_vec),
		.i_clear(clear_vec),
		.i_mask(state_reg.mask),
		.o_raw(raw_flags),
		.o_masked(masked_flags)
	);

	// ==========================================================================
	// Next state: register port, then the serial address phase
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_cond;
		logic stop_cond;
		logic own_hit;
		logic alt_hit;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_cond = 1'b0;
		stop_cond = 1'b0;
		own_hit = 1'b0;
		alt_hit = 1'b0;
		state_next = state_reg;

		// Register writes
		if (i_bus.wr) begin
			if (sel(i_bus.addr, `I2CTIC_OFS_OWN_ADDR)) begin
				state_next.own_addr = i_bus.wdata[6:0];
			end
			if (sel(i_bus.addr, `I2CTIC_OFS_MASK)) begin
				state_next.mask = i_bus.wdata[8:0];
			end
			if (sel(i_bus.addr, `I2CTIC_OFS_ALT_ADDR)) begin
				state_next.alt_en = i_bus.wdata[`I2CTIC_BIT_ALT_EN];
				state_next.alt_addr = i_bus.wdata[6:0];
			end
		end

		// Read data stand for exactly one cycle after the strobe
		state_next.rdata = 32'h00000000;
		if (i_bus.rd) begin
			case (i_bus.addr)
				`I2CTIC_OFS_OWN_ADDR: begin
					state_next.rdata = {25'h0000000, state_reg.own_addr};
				end
				`I2CTIC_OFS_MASK: begin
					state_next.rdata = {23'h000000, state_reg.mask};
				end
				`I2CTIC_OFS_RAW: begin
					state_next.rdata = {23'h000000, raw_flags};
				end
				`I2CTIC_OFS_MASKED: begin
					state_next.rdata = {23'h000000, masked_flags};
				end
				`I2CTIC_OFS_CLEAR: begin
					state_next.rdata = `I2CTIC_CLEAR_READ_VALUE;
				end
				`I2CTIC_OFS_ALT_ADDR: begin
					state_next.rdata = {24'h000000, state_reg.alt_en, state_reg.alt_addr};
				end
				default: begin
					state_next.rdata = 32'h00000000;
				end
			endcase
		end

		// Bus conditions from the synchronised pins
		state_next.evt = '0;
		state_next.scl_prev = scl_s;
		state_next.sda_prev = sda_s;
		scl_rise = scl_s && !state_reg.scl_prev;
		scl_fall = !scl_s && state_reg.scl_prev;
		start_cond = state_reg.scl_prev && scl_s && state_reg.sda_prev && !sda_s;
		stop_cond = state_reg.scl_prev && scl_s && !state_reg.sda_prev && sda_s;

		if (start_cond) begin
			// A repeated start restarts the address phase from any state
			state_next.evt.start_seen = 1'b1;
			state_next.phase = I2CTIC_ADDR;
			state_next.bit_cnt = 4'h0;
			state_next.drive_low = 1'b0;
		end else if (stop_cond) begin
			state_next.evt.stop_seen = 1'b1;
			state_next.phase = I2CTIC_IDLE;
			state_next.drive_low = 1'b0;
		end else begin
			case (state_reg.phase)
				I2CTIC_IDLE: begin
					state_next.drive_low = 1'b0;
				end
				I2CTIC_ADDR: begin
					if (scl_rise) begin
						state_next.shift = {state_reg.shift[6:0], sda_s};
						state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
					end
					// Acknowledge starts on the falling edge after the eighth bit
					if (scl_fall && state_reg.bit_cnt == `I2CTIC_ADDR_FRAME_BITS) begin
						own_hit = addr_hit(state_reg.shift[7:1], state_reg.own_addr, 1'b1);
						alt_hit = addr_hit(state_reg.shift[7:1], state_reg.alt_addr, state_reg.alt_en);
						if (own_hit || alt_hit) begin
							state_next.drive_low = 1'b1;
							state_next.phase = I2CTIC_ACK;
							state_next.evt.addr_match = 1'b1;
							state_next.evt.alt_hit = alt_hit && !own_hit;
							state_next.evt.rnw = state_reg.shift[0];
						end else begin
							state_next.phase = I2CTIC_WAIT;
						end
					end
				end
				I2CTIC_ACK: begin
					// Release after the acknowledge clock so the controller owns the line again
					if (scl_fall) begin
						state_next.drive_low = 1'b0;
						state_next.phase = I2CTIC_WAIT;
					end
				end
				I2CTIC_WAIT: begin
					state_next.drive_low = 1'b0;
				end
				default: begin
					state_next.phase = I2CTIC_IDLE;
					state_next.drive_low = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================================
	// State register; bus lines assumed idle high at reset
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_reg.own_addr <= `I2CTIC_RST_ADDR;
			state_reg.alt_addr <= `I2CTIC_RST_ADDR;
			state_reg.alt_en <= `I2CTIC_RST_ALT_EN;
			state_reg.mask <= `I2CTIC_RST_MASK;
			state_reg.rdata <= `I2CTIC_RST_RDATA;
			state_reg.scl_prev <= 1'b1;
			state_reg.sda_prev <= 1'b1;
			state_reg.phase <= I2CTIC_IDLE;
			state_reg.shift <= 8'h00;
			state_reg.bit_cnt <= 4'h0;
			state_reg.drive_low <= 1'b0;
			state_reg.evt <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Outputs; the data line is only ever pulled low, never driven high
	assign o_rdata = state_reg.rdata;
	assign o_sda = 1'b0;
	assign o_sda_oe_n = !state_reg.drive_low;
	assign o_link_evt = state_reg.evt;
	assign o_raw_status = raw_flags;
	assign o_masked_status = masked_flags;
endmodule

// File: tb/i2ctic_checker.sv
// Port-level assertions for the target interrupt-clear and alternate-address block
`timescale 1ns/1ps
`include "i2ctic_cfg.svh"
module i2ctic_checker (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire i2ctic_pkg::i2ctic_bus_req_type i_bus,
	input wire logic [31:0] o_rdata,
	input wire i2ctic_pkg::i2ctic_ext_evt_type i_ext_evt,
	input wire logic o_sda_oe_n,
	input wire i2ctic_pkg::i2ctic_link_evt_type o_link_evt,
	input wire logic [8:0] o_raw_status,
	input wire logic [8:0] o_masked_status
);
	import i2ctic_pkg::*;
	logic [8:0] clr;
	logic [8:0] set_evt;
	logic [8:0] link_evt;
	logic [8:0] mask_reg;
	logic [7:0] alt_reg;
	logic rd_clr;
	logic rd_alt;
	// ==========================================================================
	// Helpers: the mask and alternate registers are not ports, so keep shadows
	assign clr = (i_bus.wr && i_bus.addr == `I2CTIC_OFS_CLEAR) ? i_bus.wdata[8:0] : 9'h000;
	assign set_evt = {i_ext_evt, 3'h0};
	assign link_evt = {6'h00, o_link_evt.stop_seen, o_link_evt.start_seen, o_link_evt.addr_match};
	assign rd_clr = i_bus.rd && i_bus.addr == `I2CTIC_OFS_CLEAR;
	assign rd_alt = i_bus.rd && i_bus.addr == `I2CTIC_OFS_ALT_ADDR;
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mask_reg <= 9'h000;
			alt_reg <= 8'h00;
		end else if (i_bus.wr) begin
			mask_reg <= (i_bus.addr == `I2CTIC_OFS_MASK) ? i_bus.wdata[8:0] : mask_reg;
			alt_reg <= (i_bus.addr == `I2CTIC_OFS_ALT_ADDR) ? i_bus.wdata[7:0] : alt_reg;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	// ==========================================================================
	// Clears; a set in the same cycle wins, so link events excuse the flag
	property p_clr(int b);
		clr[b] && !set_evt[b] |=> (!o_raw_status[b] && !o_masked_status[b]) || link_evt[b] || $past(link_evt[b]);
	endproperty
	AST_CLR_B8: assert property (p_clr(8)) else $error("clear bit 8 failed");
	AST_CLR_B7: assert property (p_clr(7)) else $error("clear bit 7 failed");
	AST_CLR_B6: assert property (p_clr(6)) else $error("clear bit 6 failed");
	AST_CLR_B5: assert property (p_clr(5)) else $error("clear bit 5 failed");
	AST_CLR_B4: assert property (p_clr(4)) else $error("clear bit 4 failed");
	AST_CLR_B3: assert property (p_clr(3)) else $error("clear bit 3 failed");
	AST_CLR_B1: assert property (p_clr(1)) else $error("clear bit 1 failed");
	AST_CLR_B2: assert property (p_clr(2)) else $error("clear bit 2 failed");
	AST_CLR_B0: assert property (p_clr(0)) else $error("clear bit 0 failed");
	// ==========================================================================
	// Reads, masking and the alternate address
	AST_CLR_RD_DATA: assert property (rd_clr |=> o_rdata == `I2CTIC_CLEAR_READ_VALUE)
		else $error("clear register read data wrong");
	AST_CLR_RD_KEEP: assert property (rd_clr |=> (o_raw_status & $past(o_raw_status)) == $past(o_raw_status))
		else $error("read of clear register dropped a flag");
	AST_MASKED: assert property (o_masked_status == (o_raw_status & mask_reg))
		else $error("masked status wrong");
	AST_ALT_RD: assert property (rd_alt |=> o_rdata == {24'h000000, alt_reg})
		else $error("alternate address read wrong");
	AST_ALT_EN: assert property (o_link_evt.addr_match && o_link_evt.alt_hit |-> alt_reg[7])
		else $error("alternate hit while disabled");
	AST_ACK: assert property (o_link_evt.addr_match |-> ##[0:4] !o_sda_oe_n)
		else $error("no acknowledge after address match");
	cover property (clr != 9'h000);
	cover property (o_link_evt.addr_match && o_link_evt.alt_hit);
	cover property (rd_clr);
endmodule
bind i2ctic_top i2ctic_checker i_i2ctic_checker (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_bus(i_bus),
	.o_rdata(o_rdata),
	.i_ext_evt(i_ext_evt),
	.o_sda_oe_n(o_sda_oe_n),
	.o_link_evt(o_link_evt),
	.o_raw_status(o_raw_status),
	.o_masked_status(o_masked_status)
);

// File: tb/i2ctic_ctrl_model.sv
// Behavioural bus controller that addresses the target one frame at a time
`timescale 1ns/1ps
module i2ctic_ctrl_model (
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	// ==========================================================================
	// Idle: both lines released high, clock stands still outside frames
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// ==========================================================================
	// START, eight bits MSB first, ack slot, STOP; half sets prompt or slow pace
	task automatic frame(input logic [7:0] b, input int half, output logic ack);
		o_sda = 1'b0;
		#(half) o_scl = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#(half / 2) o_sda = b[i];
			#(half / 2) o_scl = 1'b1;
			#(half) o_scl = 1'b0;
		end
		#(half / 2) o_sda = 1'b1;
		#(half / 2) o_scl = 1'b1;
		#(half / 2) ack = ~i_sda;
		#(half / 2) o_scl = 1'b0;
		#(half / 2) o_sda = 1'b0;
		#(half / 2) o_scl = 1'b1;
		#(half) o_sda = 1'b1;
		#(4 * half);
	endtask
endmodule

// File: tb/tb_i2ctic_top.sv
// Self-checking bench for the target interrupt-clear and alternate-address block
`timescale 1ns/1ps
`include "i2ctic_cfg.svh"
module tb_i2ctic_top;
	import i2ctic_pkg::*;
	logic i_core_clk;
	logic i_sys_rst;
	i2ctic_bus_req_type bus;
	i2ctic_ext_evt_type evt;
	i2ctic_link_evt_type link;
	logic [31:0] rdata;
	logic sda_out;
	logic sda_oe_n;
	logic [8:0] raw;
	logic [8:0] masked;
	logic ctl_scl;
	logic ctl_sda;
	wire logic sda_line;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [1:0] lnk_q[$];
	logic ack;
	logic [8:0] mask;
	logic [6:0] alt;
	// Open-drain data line with pull-up: low if either side pulls it
	assign sda_line = ctl_sda & (sda_oe_n | sda_out);
	i2ctic_top i_i2ctic_top (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
		.i_ext_evt(evt), .i_scl(ctl_scl), .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe_n(sda_oe_n),
		.o_link_evt(link), .o_raw_status(raw), .o_masked_status(masked));
	i2ctic_ctrl_model i_i2ctic_ctrl_model (.o_scl(ctl_scl), .o_sda(ctl_sda), .i_sda(sda_line));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	// ==========================================================================
	// Compare, verdict and bus tasks; one idle cycle after each strobe
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results();
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task bus_wr(input logic [11:0] a, input logic [31:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_core_clk);
		bus.wr <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task bus_rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
		@(posedge i_core_clk);
		bus.rd <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task flags(input logic [8:0] want);
		check(32'(raw), 32'(want), "raw status");
		check(32'(masked), 32'(want & mask), "masked status");
	endtask
	// ==========================================================================
	// Read and link monitor: read data and match pulses stand one cycle only
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (rd_seen) begin
			check(rdata, exp_q.pop_front(), "read data");
		end
		if (link.addr_match) begin
			check(32'({link.alt_hit, link.rnw}), 32'(lnk_q.pop_front()), "link event");
		end
		rd_seen <= bus.rd;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	// ==========================================================================
	// Main sequence
	initial begin
		seed = 32'h4f55;
		i_sys_rst = 1'b1;
		bus = '0;
		evt = '0;
		repeat (2) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
		bus_rd(`I2CTIC_OFS_ALT_ADDR, 32'h00000000);
		mask = 9'($random(seed));
		bus_wr(`I2CTIC_OFS_MASK, {23'h000000, mask});
		// Clear bits 3 to 8 each alone, junk in the reserved bits, others must survive
		for (int b = 3; b <= 8; b++) begin
			evt <= 6'h3F;
			@(posedge i_core_clk);
			evt <= 6'h00;
			@(posedge i_core_clk);
			flags(9'h1F8);
			bus_rd(`I2CTIC_OFS_CLEAR, `I2CTIC_CLEAR_READ_VALUE);
			flags(9'h1F8);
			bus_wr(`I2CTIC_OFS_CLEAR, (32'($random(seed)) & 32'hFFFFFE00) | (32'h1 << b));
			flags(9'h1F8 & ~(9'h001 << b));
		end
		bus_wr(`I2CTIC_OFS_CLEAR, 32'h000001F8);
		// Alternate address: ignored while disabled, answered once enabled
		alt = 7'($random(seed)) | 7'h10;
		bus_wr(`I2CTIC_OFS_ALT_ADDR, {25'h0000000, alt});
		bus_rd(`I2CTIC_OFS_ALT_ADDR, {25'h0000000, alt});
		i_i2ctic_ctrl_model.frame({alt, 1'b0}, 200, ack);
		// Frame ends on a clock edge; step past it so the next strobe is not raced
		@(posedge i_core_clk);
		check(32'(ack), 32'h0, "ack while disabled");
		flags(9'h006);
		bus_wr(`I2CTIC_OFS_ALT_ADDR, {24'h000000, 1'b1, alt});
		lnk_q.push_back(2'b11);
		i_i2ctic_ctrl_model.frame({alt, 1'b1}, 600, ack);
		@(posedge i_core_clk);
		check(32'(ack), 32'h1, "ack when enabled");
		flags(9'h007);
		bus_wr(`I2CTIC_OFS_CLEAR, 32'h00000001);
		flags(9'h006);
		i_i2ctic_ctrl_model.frame({alt ^ 7'h01, 1'b0}, 200, ack);
		@(posedge i_core_clk);
		check(32'(ack), 32'h0, "ack on other address");
		flags(9'h006);
		// Primary address still answers beside the alternate one, without alt_hit
		bus_wr(`I2CTIC_OFS_OWN_ADDR, {25'h0000000, alt ^ 7'h02});
		lnk_q.push_back(2'b00);
		i_i2ctic_ctrl_model.frame({alt ^ 7'h02, 1'b0}, 200, ack);
		@(posedge i_core_clk);
		check(32'(ack), 32'h1, "ack on own address");
		bus_rd(`I2CTIC_OFS_RAW, 32'h00000007);
		bus_rd(`I2CTIC_OFS_MASKED, {23'h000000, 9'h007 & mask});
		bus_wr(`I2CTIC_OFS_CLEAR, 32'h00000001);
		flags(9'h006);
		bus_wr(`I2CTIC_OFS_CLEAR, 32'h00000002);
		flags(9'h004);
		bus_wr(`I2CTIC_OFS_CLEAR, 32'h00000004);
		flags(9'h000);
		check(32'(lnk_q.size() + exp_q.size()), 32'h0, "pending notes");
		results();
	end
endmodule
